// ===== verilog/pdf_freq_ctrl.sv
/*
 Frequency control of the clock pulse generator: the clock frequency
 control register, a model of the first PLL as a tick stream locked to
 the bus clock pin, and the core and peripheral dividers as clock
 enables on sys_clk. Assumes the bus clock pin runs well below sys_clk,
 that an external settling watchdog answers settle_start with a
 same-clock overflow pulse, and that rstn is the power-on reset.

// Operation
// - Register is 16 bits; only word writes are taken, byte writes ignored.
// - Power-on reset loads default; manual reset and standby keep contents.
// - Multiplier field bits 15,5,4: 000 x1, 001 x2, 100 x3, 010 x4.
// - Core divider bits 14,3,2: 000 1, 001 1/2, 100 1/3, 010 1/4.
// - Peripheral divider bits 13,1,0: same codes plus 101 for 1/6.
// - Bits 12 to 9, 7 and 6 read zero; software writes zero.
// - Bit 8 reads one; software writes one.
// - PLL output is bus clock times multiplier; it feeds both dividers.
// - Core clock equals bus clock times multiplier times core ratio.
// - Peripheral clock equals bus clock times multiplier times peripheral ratio.
// - Second PLL state and multiplier come only from mode pins.
// - In pin-input mode the bus clock pin is an input feeding the PLL.
// - Multiplier change stops clocks until watchdog overflow, then resumes.
// - Divider-only change takes effect at once without settling.
*/
`timescale 1ns/1ps
module pdf_freq_ctrl
   import pdf_pkg::*;
(
   // Clock and power-on reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic              reg_word,
   output logic      [DATA_W-1:0] reg_rdata,
   // Bus clock pin, two-way
   input  wire logic              bus_clock_pin_i,
   output logic                   bus_clock_pin_o,
   output logic                   bus_clock_pin_oe,
   // Clock mode pins
   input  wire logic [2:0]        mode_pins,
   // Settling watchdog
   output logic                   settle_start,
   input  wire logic              settle_overflow,
   // Generated clock enables and status
   output logic                   pll_clk_en,
   output logic                   core_clk_en,
   output logic                   periph_clk_en,
   output logic                   cpu_pause,
   output logic                   pll_locked,
   output logic                   pll2_on,
   output logic      [2:0]        pll2_mult
);

   // Register fields
   logic [2:0]  mult_code_r;
   logic [2:0]  core_code_r;
   logic [2:0]  peri_code_r;
   logic [15:0] freq_word;

   // Pins and straps
   logic        bclk_s1_r;
   logic        bclk_s2_r;
   logic        bclk_s3_r;
   logic        bclk_rise;
   logic [2:0]  mode_s1_r;
   logic [2:0]  mode_s2_r;
   logic [2:0]  mode_r;
   logic [1:0]  strap_cnt_r;
   logic        strap_done_r;

   // PLL model
   logic [PER_W-1:0] per_cnt_r;
   logic [PER_W-1:0] period_r;
   logic [PER_W-1:0] per_meas;
   logic [2:0]       lock_cnt_r;
   logic             per_close;
   logic [PER_W:0]   acc_r;
   logic [PER_W:0]   acc_nxt;
   logic             pll_tick_nxt;
   logic [2:0]       mult_val;
   logic [2:0]       core_val;
   logic [2:0]       peri_val;

   // Sequencing
   pdf_state_e  state_r;
   logic        freq_hit;
   logic        stat_hit;
   logic        word_wr;
   logic        mult_change;
   logic        run_clocks;

   // Field defaults split out at elaboration, so reset loads plain constants
   localparam logic [2:0] MULT_RST = pdf_field(FREQ_CTRL_RST, MULT_HI, MULT_MID, MULT_LO);
   localparam logic [2:0] CORE_RST = pdf_field(FREQ_CTRL_RST, CORE_HI, CORE_MID, CORE_LO);
   localparam logic [2:0] PERI_RST = pdf_field(FREQ_CTRL_RST, PERI_HI, PERI_MID, PERI_LO);

   // Register decode
   assign freq_hit = (reg_addr == OFS_FREQ_CTRL);
   assign stat_hit = (reg_addr == OFS_STATUS);
   assign word_wr  = reg_wr && freq_hit && reg_word;
   assign mult_change = word_wr &&
      (pdf_field(reg_wdata, MULT_HI, MULT_MID, MULT_LO) != mult_code_r);

   // Power-on reset only; no manual reset or standby input touches these
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mult_code_r <= MULT_RST;
         core_code_r <= CORE_RST;
         peri_code_r <= PERI_RST;
      end
      else if (word_wr)
      begin
         // Codes stored as written, reserved ones included
         mult_code_r <= pdf_field(reg_wdata, MULT_HI, MULT_MID, MULT_LO);
         core_code_r <= pdf_field(reg_wdata, CORE_HI, CORE_MID, CORE_LO);
         peri_code_r <= pdf_field(reg_wdata, PERI_HI, PERI_MID, PERI_LO);
      end
   end

   // Reassemble the scattered fields; reserved bits are constants
   always_comb
   begin
      freq_word              = 16'h0000;
      freq_word[RSV_ONE_BIT] = 1'b1;
      freq_word[MULT_HI]     = mult_code_r[2];
      freq_word[MULT_MID]    = mult_code_r[1];
      freq_word[MULT_LO]     = mult_code_r[0];
      freq_word[CORE_HI]     = core_code_r[2];
      freq_word[CORE_MID]    = core_code_r[1];
      freq_word[CORE_LO]     = core_code_r[0];
      freq_word[PERI_HI]     = peri_code_r[2];
      freq_word[PERI_MID]    = peri_code_r[1];
      freq_word[PERI_LO]     = peri_code_r[0];
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= 16'h0000;
      else if (reg_rd && freq_hit)
         reg_rdata <= freq_word;
      else if (reg_rd && stat_hit)
      begin
         reg_rdata                                <= 16'h0000;
         reg_rdata[STAT_PER_LSB +: PER_W]         <= period_r;
         reg_rdata[STAT_LOCK_BIT]                 <= pll_locked;
         reg_rdata[STAT_SETL_BIT]                 <= cpu_pause;
         reg_rdata[STAT_MODE_LSB +: 3]            <= mode_r;
      end
      else
         reg_rdata <= 16'h0000;
   end

   // Bus clock pin synchroniser; rise is taken from the second and third stages
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bclk_s1_r <= 1'b0;
         bclk_s2_r <= 1'b0;
         bclk_s3_r <= 1'b0;
      end
      else
      begin
         bclk_s1_r <= bus_clock_pin_i;
         bclk_s2_r <= bclk_s1_r;
         bclk_s3_r <= bclk_s2_r;
      end
   end

   assign bclk_rise = bclk_s2_r && !bclk_s3_r;

   // Only the pin-input mode is built here, so the pin is never driven
   assign bus_clock_pin_o  = 1'b0;
   assign bus_clock_pin_oe = 1'b0;

   // Mode pins synchronised, then held once sampled after reset release
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_s1_r <= 3'h0;
         mode_s2_r <= 3'h0;
      end
      else
      begin
         mode_s1_r <= mode_pins;
         mode_s2_r <= mode_s1_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_cnt_r  <= 2'h0;
         strap_done_r <= 1'b0;
         mode_r       <= MODE_PIN_IN;
      end
      else if (!strap_done_r)
      begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == STRAP_WAIT)
         begin
            strap_done_r <= 1'b1;
            mode_r       <= mode_s2_r;
         end
      end
   end

   // Second PLL follows the mode straps alone
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pll2_on   <= 1'b0;
         pll2_mult <= 3'h1;
      end
      else
      begin
         pll2_on   <= (mode_r != MODE_PIN_IN);
         pll2_mult <= (mode_r == MODE_X4A || mode_r == MODE_X4B) ? 3'h4 : 3'h1;
      end
   end

   // Bus clock period in sys_clk cycles; saturation means the clock stopped
   assign per_meas  = per_cnt_r + 8'h01;
   assign per_close = (per_meas >= period_r) ? (per_meas - period_r <= PER_TOL)
                                             : (period_r - per_meas <= PER_TOL);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         per_cnt_r <= 8'h00;
      else if (bclk_rise)
         per_cnt_r <= 8'h00;
      else if (per_cnt_r != PER_MAX)
         per_cnt_r <= per_cnt_r + 8'h01;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         period_r   <= PER_MAX;
         lock_cnt_r <= 3'h0;
      end
      else if (per_cnt_r == PER_MAX)
         lock_cnt_r <= 3'h0;
      else if (bclk_rise)
      begin
         period_r <= per_meas;
         if (!per_close)
            lock_cnt_r <= 3'h0;
         else if (lock_cnt_r != LOCK_PERIODS)
            lock_cnt_r <= lock_cnt_r + 3'h1;
      end
   end

   assign pll_locked = (lock_cnt_r == LOCK_PERIODS);

   // PLL output: mult ticks per measured bus clock period
   assign mult_val = pdf_mult(mult_code_r);
   assign core_val = pdf_div(core_code_r, 1'b0);
   assign peri_val = pdf_div(peri_code_r, 1'b1);

   always_comb
   begin
      acc_nxt      = acc_r + {{(PER_W-2){1'b0}}, mult_val};
      pll_tick_nxt = 1'b0;
      if (acc_nxt >= {1'b0, period_r})
      begin
         acc_nxt      = acc_nxt - {1'b0, period_r};
         pll_tick_nxt = 1'b1;
      end
   end

   // Reserved codes are not trapped; the PLL then runs at x1
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acc_r      <= '0;
         pll_clk_en <= 1'b0;
      end
      else if (!pll_locked)
      begin
         acc_r      <= '0;
         pll_clk_en <= 1'b0;
      end
      else
      begin
         acc_r      <= acc_nxt;
         pll_clk_en <= pll_tick_nxt;
      end
   end

   // Settling sequence after a multiplier rewrite
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         state_r <= ST_RUN;
      else
      begin
         unique case (state_r)
            ST_RUN:
               if (mult_change)
                  state_r <= ST_SETTLE;
            ST_SETTLE:
               if (settle_overflow && !mult_change)
                  state_r <= ST_RUN;
            default:
               state_r <= ST_RUN;
         endcase
      end
   end

   // A rewrite to a new multiplier during settling restarts the watchdog
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         settle_start <= 1'b0;
      else
         settle_start <= mult_change;
   end

   assign cpu_pause  = (state_r == ST_SETTLE);
   // Divider-only writes never enter settling, so they act at once
   assign run_clocks = (state_r == ST_RUN) && !mult_change;

   // Both dividers take the same PLL tick stream
   pdf_divider u_core_div (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .tick_in  (pll_clk_en),
      .ratio    (core_val),
      .run      (run_clocks),
      .tick_out (core_clk_en)
   );

   pdf_divider u_periph_div (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .tick_in  (pll_clk_en),
      .ratio    (peri_val),
      .run      (run_clocks),
      .tick_out (periph_clk_en)
   );

endmodule : pdf_freq_ctrl

// ===== verilog/pdf_pkg.sv
/*
 Shared constants for the clock frequency control block: register
 offsets, field positions, reset value, ratio codes and decode functions.
 Assumes a single 250 MHz system clock domain.
*/
package pdf_pkg;

   // Register port geometry
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 16;
   localparam logic [7:0]  OFS_FREQ_CTRL = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;

   // Frequency control register layout
   localparam logic [15:0] FREQ_CTRL_RST = 16'h0102;
   localparam int          MULT_HI       = 15;
   localparam int          MULT_MID      = 5;
   localparam int          MULT_LO       = 4;
   localparam int          CORE_HI       = 14;
   localparam int          CORE_MID      = 3;
   localparam int          CORE_LO       = 2;
   localparam int          PERI_HI       = 13;
   localparam int          PERI_MID      = 1;
   localparam int          PERI_LO       = 0;
   localparam int          RSV_ONE_BIT   = 8;

   // Status register layout
   localparam int          STAT_PER_LSB  = 0;
   localparam int          STAT_LOCK_BIT = 8;
   localparam int          STAT_SETL_BIT = 9;
   localparam int          STAT_MODE_LSB = 10;

   // Three-bit ratio codes, written {hi, mid, lo}
   localparam logic [2:0]  CODE_X1       = 3'h0;
   localparam logic [2:0]  CODE_X2       = 3'h1;
   localparam logic [2:0]  CODE_X3       = 3'h4;
   localparam logic [2:0]  CODE_X4       = 3'h2;
   localparam logic [2:0]  CODE_X6       = 3'h5;

   // Clock modes: bus clock pin input with the second PLL off, and two with the second PLL at x4
   localparam logic [2:0]  MODE_PIN_IN   = 3'h7;
   localparam logic [2:0]  MODE_X4A      = 3'h1;
   localparam logic [2:0]  MODE_X4B      = 3'h2;

   // Bus clock period measurement and lock model
   localparam int          PER_W         = 8;
   localparam logic [7:0]  PER_MAX       = 8'hff;
   localparam logic [7:0]  PER_TOL       = 8'h01;
   localparam logic [2:0]  LOCK_PERIODS  = 3'h4;
   localparam logic [1:0]  STRAP_WAIT    = 2'h3;

   typedef enum logic [1:0] {
      ST_RUN    = 2'b01,
      ST_SETTLE = 2'b10
   } pdf_state_e;

   function automatic logic [2:0] pdf_field(input logic [15:0] w, input int hi,
                                            input int mid, input int lo);
      pdf_field = {w[hi], w[mid], w[lo]};
   endfunction : pdf_field

   // Reserved codes fall back to x1; their effect is left undefined
   function automatic logic [2:0] pdf_mult(input logic [2:0] code);
      unique case (code)
         CODE_X2: pdf_mult = 3'h2;
         CODE_X3: pdf_mult = 3'h3;
         CODE_X4: pdf_mult = 3'h4;
         default: pdf_mult = 3'h1;
      endcase
   endfunction : pdf_mult

   function automatic logic [2:0] pdf_div(input logic [2:0] code, input logic six_ok);
      unique case (code)
         CODE_X2: pdf_div = 3'h2;
         CODE_X3: pdf_div = 3'h3;
         CODE_X4: pdf_div = 3'h4;
         CODE_X6: pdf_div = six_ok ? 3'h6 : 3'h1;
         default: pdf_div = 3'h1;
      endcase
   endfunction : pdf_div

endpackage : pdf_pkg

// ===== verilog/pdf_divider.sv
/*
 Tick divider: passes one of every N input ticks as a one-cycle output
 tick. Assumes ticks and ratio come from logic on the same clock.
*/
`timescale 1ns/1ps
module pdf_divider
   import pdf_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Input tick stream
   input  wire logic       tick_in,
   input  wire logic [2:0] ratio,
   input  wire logic       run,
   // Divided tick
   output logic            tick_out
);

   logic [2:0] cnt_r;
   logic       hit;

   // A compare rather than a reload lets a new ratio act at once
   assign hit = (cnt_r >= ratio - 3'h1);

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         cnt_r <= 3'h0;
      else if (tick_in)
         cnt_r <= hit ? 3'h0 : cnt_r + 3'h1;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         tick_out <= 1'b0;
      else
         tick_out <= tick_in && hit && run;
   end

endmodule : pdf_divider

// ===== verification/pdf_freq_ctrl_asserts.sv
/*
 Checker for pdf_freq_ctrl: read port timing, reserved bits,
 settling handshake and clock enables. Sees only top-level ports.
*/
`timescale 1ns/1ps
module pdf_freq_ctrl_asserts
   import pdf_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              rstn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic              reg_word,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Pin, settling and enables
   input wire logic              bus_clock_pin_oe,
   input wire logic              settle_start,
   input wire logic              settle_overflow,
   input wire logic              pll_clk_en,
   input wire logic              core_clk_en,
   input wire logic              periph_clk_en,
   input wire logic              cpu_pause,
   input wire logic              pll2_on,
   input wire logic [2:0]        pll2_mult
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   logic       wr_ctrl;
   logic [2:0] new_mult;
   logic [2:0] mult_r;
   assign wr_ctrl  = reg_wr && reg_word && (reg_addr == OFS_FREQ_CTRL);
   assign new_mult = {reg_wdata[MULT_HI], reg_wdata[MULT_MID], reg_wdata[MULT_LO]};

   // Shadow of the multiplier, to tell settling writes apart
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn)
         mult_r <= 3'h0;
      else if (wr_ctrl)
         mult_r <= new_mult;

   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_rsv_read: assert property (reg_rd && reg_addr == OFS_FREQ_CTRL |=>
      reg_rdata[12:9] == 4'h0 && reg_rdata[7:6] == 2'h0 && reg_rdata[RSV_ONE_BIT])
      else $error("reserved bits read wrong");
   a_mult_settle: assert property (wr_ctrl && new_mult != mult_r |=> settle_start && cpu_pause)
      else $error("multiplier change did not start settling");
   a_div_direct: assert property (wr_ctrl && new_mult == mult_r && !cpu_pause |=> !settle_start)
      else $error("divider-only write started settling");
   a_pause_gate: assert property (cpu_pause |-> !core_clk_en && !periph_clk_en)
      else $error("clock enable while paused");
   a_pause_end: assert property (cpu_pause && settle_overflow && !wr_ctrl |=> !cpu_pause)
      else $error("pause did not end on overflow");
   a_pause_hold: assert property (cpu_pause && !settle_overflow |=> cpu_pause)
      else $error("pause ended without overflow");
   a_div_source: assert property (core_clk_en || periph_clk_en |-> $past(pll_clk_en))
      else $error("divided enable without a PLL tick");
   a_pin_input: assert property (!bus_clock_pin_oe)
      else $error("bus clock pin driven");
   a_pll2_off: assert property (!pll2_on |-> pll2_mult == 3'h1)
      else $error("second PLL multiplier wrong while off");

   c_settle: cover property (settle_start);
   c_overflow: cover property (cpu_pause && settle_overflow);
   c_both_en: cover property (core_clk_en && periph_clk_en);
endmodule : pdf_freq_ctrl_asserts

bind pdf_freq_ctrl pdf_freq_ctrl_asserts u_pdf_freq_ctrl_asserts (.sys_clk, .rstn,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_word, .reg_rdata, .bus_clock_pin_oe,
   .settle_start, .settle_overflow, .pll_clk_en, .core_clk_en, .periph_clk_en,
   .cpu_pause, .pll2_on, .pll2_mult);

// ===== verification/pdf_clk_src_model.sv
/*
 External clock source on the bus clock pin.
 Assumes the block only listens to the pin and never drives it.
*/
`timescale 1ns/1ps
module pdf_clk_src_model
#(
   parameter int HALF_NS = 24
)
(
   // Control
   input wire logic run,
   // Pin
   output logic     pin
);
   // Stopped clock rests low; offset keeps edges off sys_clk edges
   initial
   begin
      pin = 1'b0;
      #1.5;
      forever
      begin
         #(HALF_NS);
         pin = run ? ~pin : 1'b0;
      end
   end
endmodule : pdf_clk_src_model

// ===== verification/pdf_freq_ctrl_tb.sv
/*
 Testbench for pdf_freq_ctrl: register access, ratio table, settling.
 Assumes a bus clock of 12 sys_clk cycles from the source model.
*/
`timescale 1ns/1ps
module pdf_freq_ctrl_tb
   import pdf_pkg::*;
;
   logic              sys_clk, rstn, reg_wr, reg_rd, reg_word, run, pin, pin_oe, pin_o;
   logic              settle_overflow, settle_start, pll_clk_en, core_clk_en;
   logic              periph_clk_en, cpu_pause, pll_locked, pll2_on;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [2:0]        mode_pins, pll2_mult, cur_mult;
   int                mismatches, tests_run;
   localparam logic [15:0] VALS [15] = '{16'h0100, 16'h0101, 16'h0102, 16'h0111,
      16'h0112, 16'h0115, 16'h0116, 16'h0122, 16'h0126, 16'h012a, 16'ha100,
      16'ha101, 16'he100, 16'he101, 16'h0102};

   pdf_clk_src_model u_pdf_clk_src_model (.run(run), .pin(pin));
   pdf_freq_ctrl u_pdf_freq_ctrl (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_word, .reg_rdata, .bus_clock_pin_i(pin), .bus_clock_pin_o(pin_o),
      .bus_clock_pin_oe(pin_oe), .mode_pins, .settle_start, .settle_overflow,
      .pll_clk_en, .core_clk_en, .periph_clk_en, .cpu_pause, .pll_locked,
      .pll2_on, .pll2_mult);

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   task automatic check_val(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic check_near(input string what, input int exp, input int got);
      tests_run++;
      if (got < exp - 1 || got > exp + 1)
      begin
         mismatches++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_near

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      reg_word  <= w;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check_val(what, exp, reg_rdata);
   endtask : rd

   function automatic int ratio(input logic [2:0] c);
      case (c)
         3'b001:  return 2;
         3'b100:  return 3;
         3'b010:  return 4;
         3'b101:  return 6;
         default: return 1;
      endcase
   endfunction : ratio

   task automatic wait_lock();
      int n;
      n = 0;
      while (pll_locked !== 1'b1 && n < 400)
      begin
         @(posedge sys_clk);
         n++;
      end
      check_val("pll_locked", 16'h1, {15'h0, pll_locked});
   endtask : wait_lock

   // Counts enables over 12 bus periods and compares ratios
   task automatic apply(input logic [15:0] v);
      int   p, c, q;
      logic chg;
      p = 0;
      c = 0;
      q = 0;
      chg = {v[15], v[5], v[4]} != cur_mult;
      cur_mult = {v[15], v[5], v[4]};
      wr(OFS_FREQ_CTRL, v, 1'b1);
      // Pulse stands only in the cycle right after the write edge
      #1;
      check_val("settle_start", {15'h0, chg}, {15'h0, settle_start});
      check_val("cpu_pause set", {15'h0, chg}, {15'h0, cpu_pause});
      if (chg)
      begin
         repeat (16) @(posedge sys_clk);
         settle_overflow <= 1'b1;
         @(posedge sys_clk);
         settle_overflow <= 1'b0;
         #1;
         check_val("cpu_pause", 16'h0, {15'h0, cpu_pause});
      end
      wait_lock();
      repeat (144)
      begin
         @(posedge sys_clk);
         #1;
         p += int'(pll_clk_en === 1'b1);
         c += int'(core_clk_en === 1'b1);
         q += int'(periph_clk_en === 1'b1);
      end
      check_near("pll ticks", 12 * ratio(cur_mult), p);
      check_near("core ticks", p / ratio({v[14], v[3], v[2]}), c);
      check_near("periph ticks", p / ratio({v[13], v[1], v[0]}), q);
   endtask : apply

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial
   begin
      #100000;
      mismatches++;
      report_and_stop();
   end

   initial
   begin
      rstn            = 1'b0;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      reg_word        = 1'b1;
      reg_addr        = 8'h00;
      reg_wdata       = 16'h0000;
      settle_overflow = 1'b0;
      mode_pins       = MODE_PIN_IN;
      run             = 1'b1;
      cur_mult        = 3'h0;
      mismatches      = 0;
      tests_run       = 0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(OFS_FREQ_CTRL, FREQ_CTRL_RST, "freq reset");
      repeat (6) @(posedge sys_clk);
      #1;
      check_val("pll2_on", 16'h0, {15'h0, pll2_on});
      check_val("pll2_mult", 16'h1, {13'h0, pll2_mult});
      check_val("pin_oe", 16'h0, {15'h0, pin_oe});
      check_val("pin_o", 16'h0, {15'h0, pin_o});
      wr(OFS_FREQ_CTRL, 16'h0111, 1'b0);
      rd(OFS_FREQ_CTRL, FREQ_CTRL_RST, "byte write");
      wr(OFS_FREQ_CTRL, 16'h1ec2, 1'b1);
      rd(OFS_FREQ_CTRL, 16'h0102, "reserved bits");
      rd(8'h10, 16'h0000, "unmapped");
      for (int i = 0; i < 15; i++)
         apply(VALS[i]);
      // Locked on a 12-cycle bus clock, mode 7, not settling
      rd(OFS_STATUS, {3'h0, MODE_PIN_IN, 1'b0, 1'b1, 8'h0c}, "status");
      run <= 1'b0;
      repeat (300) @(posedge sys_clk);
      #1;
      check_val("lock lost", 16'h0, {15'h0, pll_locked});
      mode_pins <= MODE_X4A;
      rstn      <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(OFS_FREQ_CTRL, FREQ_CTRL_RST, "freq after reset");
      repeat (6) @(posedge sys_clk);
      #1;
      check_val("pll2_on mode1", 16'h1, {15'h0, pll2_on});
      check_val("pll2_mult mode1", 16'h4, {13'h0, pll2_mult});
      report_and_stop();
   end
endmodule : pdf_freq_ctrl_tb
